/* File: verilog/flash_erase_defines.svh */
`ifndef FLASH_ERASE_DEFINES_SVH
`define FLASH_ERASE_DEFINES_SVH

// opcodes
`define OP_WRITE_ENABLE    8'h06
`define OP_WRITE_DISABLE   8'h04
`define OP_READ_STATUS     8'h05
`define OP_PAGE_ERASE      8'h81
`define OP_SECTOR_ERASE    8'h20
`define OP_HALF_BLOCK_ERASE 8'h52
`define OP_BLOCK_ERASE     8'hD8
`define OP_CHIP_ERASE_A    8'h60
`define OP_CHIP_ERASE_B    8'hC7

// frame lengths in link clocks
`define FRAME_BITS_OPCODE  6'h08
`define FRAME_BITS_ADDR    6'h20
`define FRAME_BITS_MAX     6'h3F

// status byte layout
`define STAT_WIP_BIT       0
`define STAT_WEL_BIT       1
`define STAT_PROT_LSB      2

// region alignment (low address bits cleared)
`define PAGE_ALIGN_BITS    8
`define SECTOR_ALIGN_BITS  12
`define HALF_ALIGN_BITS    15
`define BLOCK_ALIGN_BITS   16
`define BLOCK_INDEX_MSB    20
`define BLOCK_COUNT        7'h20

// timing
`define SYS_CLK_PERIOD_NS       4
`define PAGE_ERASE_TIME_NS      8000
`define SECTOR_ERASE_TIME_NS    16000
`define HALF_BLOCK_ERASE_TIME_NS 24000
`define BLOCK_ERASE_TIME_NS     32000
`define CHIP_ERASE_TIME_NS      40000
`define PAGE_ERASE_CYCLES       (`PAGE_ERASE_TIME_NS / `SYS_CLK_PERIOD_NS)
`define SECTOR_ERASE_CYCLES     (`SECTOR_ERASE_TIME_NS / `SYS_CLK_PERIOD_NS)
`define HALF_BLOCK_ERASE_CYCLES (`HALF_BLOCK_ERASE_TIME_NS / `SYS_CLK_PERIOD_NS)
`define BLOCK_ERASE_CYCLES      (`BLOCK_ERASE_TIME_NS / `SYS_CLK_PERIOD_NS)
`define CHIP_ERASE_CYCLES       (`CHIP_ERASE_TIME_NS / `SYS_CLK_PERIOD_NS)
`define SCLK_HALF_NS            24
`define SCLK_HALF_CYCLES        ((`SCLK_HALF_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)

`endif

/* File: verilog/flash_erase_pkg.sv */
`default_nettype none
package flash_erase_pkg;
  typedef enum logic [2:0] {
    ERASE_PAGE,
    ERASE_SECTOR,
    ERASE_HALF_BLOCK,
    ERASE_BLOCK,
    ERASE_CHIP
  } erase_kind_type;

  typedef enum logic {
    DEV_IDLE,
    DEV_ERASE
  } dev_state_type;

  typedef enum logic [2:0] {
    HOST_IDLE,
    HOST_LOW,
    HOST_HIGH,
    HOST_TRAIL,
    HOST_GAP
  } host_state_type;
endpackage
`default_nettype wire

/* File: verilog/flash_link_if.sv */
`default_nettype none
interface flash_link_if;
  logic sclk;     // link clock, idle low
  logic cs_n;     // chip select, active low
  logic si;       // serial data to device
  logic so_dev;   // device serial output value
  logic so_oe;    // device drives serial output
  logic so_line;  // resolved serial output wire

  // undriven line reads low
  assign so_line = so_oe & so_dev;

  modport device (input sclk, input cs_n, input si, output so_dev, output so_oe);
  modport host   (output sclk, output cs_n, output si, input so_line);
endinterface
`default_nettype wire

/* File: verilog/flash_erase_device.sv */
`include "flash_erase_defines.svh"
`default_nettype none
module flash_erase_device
  import flash_erase_pkg::*;
#(
  parameter int unsigned PAGE_CYCLES   = `PAGE_ERASE_CYCLES,
  parameter int unsigned SECTOR_CYCLES = `SECTOR_ERASE_CYCLES,
  parameter int unsigned HALF_CYCLES   = `HALF_BLOCK_ERASE_CYCLES,
  parameter int unsigned BLOCK_CYCLES  = `BLOCK_ERASE_CYCLES,
  parameter int unsigned CHIP_CYCLES   = `CHIP_ERASE_CYCLES
) (
  input  wire logic           i_clk_sys,       // system clock
  input  wire logic           i_rst,           // sync reset, active high
  input  wire logic [4:0]     i_protect,       // block-protect bits 4..0
  output logic                o_wip,           // erase in progress
  output logic                o_wel,           // write enable latch
  output logic                o_erase_start,   // pulse: erase begins
  output var erase_kind_type  o_erase_kind,    // kind of running erase
  output logic [23:0]         o_erase_base,    // aligned base of region
  output logic                o_erase_done,    // pulse: erase finished
  output logic                o_cmd_rejected,  // pulse: erase refused
  flash_link_if.device        link             // serial link
);

  // link domain: frame capture
  logic        fresh_r;
  logic [5:0]  bit_cnt_r;
  logic [31:0] shift_r;
  logic [7:0]  op_r;
  logic [7:0]  stat_meta_r;
  logic [7:0]  stat_r;
  logic        so_r;
  logic        so_oe_r;

  // async preset only marks the next edge as a frame start
  always_ff @(posedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      fresh_r <= 1'b1;
    end else begin
      fresh_r <= 1'b0;
    end
  end

  always_ff @(posedge link.sclk) begin
    if (fresh_r) begin
      bit_cnt_r <= 6'h01;
    end else if (bit_cnt_r != `FRAME_BITS_MAX) begin
      bit_cnt_r <= bit_cnt_r + 6'h01;
    end
  end

  always_ff @(posedge link.sclk) begin
    shift_r <= {shift_r[30:0], link.si};
  end

  always_ff @(posedge link.sclk) begin
    if (!fresh_r && bit_cnt_r == 6'h07) begin
      op_r <= {shift_r[6:0], link.si};
    end
  end

  // status levels cross into the link domain
  always_ff @(posedge link.sclk) begin
    stat_meta_r <= {1'b0, i_protect, o_wel, o_wip};
    stat_r      <= stat_meta_r;
  end

  // status shifts out msb first, repeating every byte
  always_ff @(negedge link.sclk or posedge link.cs_n) begin
    if (link.cs_n) begin
      so_oe_r <= 1'b0;
    end else begin
      so_oe_r <= (bit_cnt_r >= `FRAME_BITS_OPCODE) && (op_r == `OP_READ_STATUS);
    end
  end

  always_ff @(negedge link.sclk) begin
    so_r <= stat_r[~bit_cnt_r[2:0]];
  end

  assign link.so_dev = so_r;
  assign link.so_oe  = so_oe_r;

  // system domain
  logic           cs_meta_r;
  logic           cs_sync_r;
  logic           cs_prev_r;
  logic           frame_end;
  dev_state_type  state_r;
  logic [31:0]    timer_r;
  logic           is_erase_op;
  logic           framed;
  logic           prot_hit;
  logic           start_ok;
  logic           is_wren;
  logic           is_wrdi;
  erase_kind_type req_kind;
  logic [23:0]    req_base;
  logic [31:0]    req_cycles;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cs_meta_r <= 1'b1;
      cs_sync_r <= 1'b1;
      cs_prev_r <= 1'b1;
    end else begin
      cs_meta_r <= link.cs_n;
      cs_sync_r <= cs_meta_r;
      cs_prev_r <= cs_sync_r;
    end
  end

  // frame registers are static once select is high: the link clock
  // stops, so they are read only after select has been synchronised
  assign frame_end = cs_sync_r & ~cs_prev_r;

  // top or bottom group of 64 KiB blocks, sized by bits 2..0
  function automatic logic in_protected(input logic [23:0] addr, input logic [4:0] bp);
    logic [6:0] blk;
    logic [6:0] n;
    blk = {2'b00, addr[`BLOCK_INDEX_MSB:`BLOCK_ALIGN_BITS]};
    n   = 7'h01 << (bp[2:0] - 3'h1);
    if (bp[2:0] == 3'h0) begin
      in_protected = 1'b0;
    end else if (bp[3]) begin
      in_protected = blk < n;
    end else begin
      in_protected = (n >= `BLOCK_COUNT) || (blk >= `BLOCK_COUNT - n);
    end
  endfunction

  always_comb begin
    is_erase_op = 1'b1;
    req_kind    = ERASE_PAGE;
    req_base    = shift_r[23:0];
    req_cycles  = PAGE_CYCLES;
    framed      = (bit_cnt_r == `FRAME_BITS_ADDR);
    prot_hit    = in_protected(shift_r[23:0], i_protect);
    if (bit_cnt_r < `FRAME_BITS_OPCODE) begin
      is_erase_op = 1'b0;
    end else if (op_r == `OP_PAGE_ERASE) begin
      req_base = {shift_r[23:`PAGE_ALIGN_BITS], 8'h00};
    end else if (op_r == `OP_SECTOR_ERASE) begin
      req_kind   = ERASE_SECTOR;
      req_base   = {shift_r[23:`SECTOR_ALIGN_BITS], 12'h000};
      req_cycles = SECTOR_CYCLES;
    end else if (op_r == `OP_HALF_BLOCK_ERASE) begin
      req_kind   = ERASE_HALF_BLOCK;
      req_base   = {shift_r[23:`HALF_ALIGN_BITS], 15'h0000};
      req_cycles = HALF_CYCLES;
    end else if (op_r == `OP_BLOCK_ERASE) begin
      req_kind   = ERASE_BLOCK;
      req_base   = {shift_r[23:`BLOCK_ALIGN_BITS], 16'h0000};
      req_cycles = BLOCK_CYCLES;
    end else if (op_r == `OP_CHIP_ERASE_A || op_r == `OP_CHIP_ERASE_B) begin
      req_kind   = ERASE_CHIP;
      req_base   = 24'h000000;
      req_cycles = CHIP_CYCLES;
      framed     = (bit_cnt_r == `FRAME_BITS_OPCODE);
      prot_hit   = (i_protect != 5'h00);
    end else begin
      is_erase_op = 1'b0;
    end
  end

  assign is_wren  = (bit_cnt_r == `FRAME_BITS_OPCODE) && (op_r == `OP_WRITE_ENABLE);
  assign is_wrdi  = (bit_cnt_r == `FRAME_BITS_OPCODE) && (op_r == `OP_WRITE_DISABLE);
  // busy state drops every command; status needs no system logic
  assign start_ok = frame_end && (state_r == DEV_IDLE) && is_erase_op
                    && framed && o_wel && !prot_hit;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_r <= DEV_IDLE;
      timer_r <= 32'h00000000;
      o_wip   <= 1'b0;
    end else begin
      case (state_r)
        DEV_IDLE: begin
          if (start_ok) begin
            state_r <= DEV_ERASE;
            timer_r <= req_cycles - 32'h00000001;
            o_wip   <= 1'b1;
          end
        end
        DEV_ERASE: begin
          if (timer_r == 32'h00000000) begin
            state_r <= DEV_IDLE;
            o_wip   <= 1'b0;
          end else begin
            timer_r <= timer_r - 32'h00000001;
          end
        end
        default: begin
          state_r <= DEV_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_wel <= 1'b0;
    end else if (start_ok) begin
      o_wel <= 1'b0;
    end else if (frame_end && state_r == DEV_IDLE && is_wren) begin
      o_wel <= 1'b1;
    end else if (frame_end && state_r == DEV_IDLE && is_wrdi) begin
      o_wel <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_erase_start  <= 1'b0;
      o_erase_kind   <= ERASE_PAGE;
      o_erase_base   <= 24'h000000;
      o_erase_done   <= 1'b0;
      o_cmd_rejected <= 1'b0;
    end else begin
      o_erase_start  <= start_ok;
      o_erase_done   <= (state_r == DEV_ERASE) && (timer_r == 32'h00000000);
      o_cmd_rejected <= frame_end && is_erase_op && !start_ok;
      if (start_ok) begin
        o_erase_kind <= req_kind;
        o_erase_base <= req_base;
      end
    end
  end

endmodule
`default_nettype wire

/* File: verilog/flash_erase_host.sv */
`include "flash_erase_defines.svh"
`default_nettype none
module flash_erase_host
  import flash_erase_pkg::*;
#(
  parameter int unsigned HALF_PERIOD = `SCLK_HALF_CYCLES
) (
  input  wire logic        i_clk_sys,    // system clock
  input  wire logic        i_rst,        // sync reset, active high
  input  wire logic        i_cmd_valid,  // command request
  input  wire logic [7:0]  i_cmd_op,     // opcode
  input  wire logic [23:0] i_cmd_addr,   // address, sent after opcode
  input  wire logic [5:0]  i_cmd_bits,   // link clocks in frame
  output logic             o_cmd_ready,  // idle, takes a request
  output logic             o_rsp_valid,  // pulse: frame finished
  output logic [7:0]       o_rsp_data,   // last 8 bits read back
  flash_link_if.host       link          // serial link
);

  host_state_type state_r;
  logic [7:0]     div_r;
  logic           div_done;
  logic [31:0]    tx_r;
  logic [5:0]     left_r;
  logic [7:0]     rx_r;
  logic           so_meta_r;
  logic           so_sync_r;
  logic           sclk_r;
  logic           cs_n_r;
  logic           si_r;

  // half period must cover the two-flop delay on the return line
  assign div_done = (div_r == 8'(HALF_PERIOD - 1));

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      so_meta_r <= 1'b0;
      so_sync_r <= 1'b0;
    end else begin
      so_meta_r <= link.so_line;
      so_sync_r <= so_meta_r;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || state_r == HOST_IDLE || div_done) begin
      div_r <= 8'h00;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_r     <= HOST_IDLE;
      sclk_r      <= 1'b0;
      cs_n_r      <= 1'b1;
      si_r        <= 1'b0;
      tx_r        <= 32'h00000000;
      left_r      <= 6'h00;
      rx_r        <= 8'h00;
      o_cmd_ready <= 1'b1;
      o_rsp_valid <= 1'b0;
      o_rsp_data  <= 8'h00;
    end else begin
      o_rsp_valid <= 1'b0;
      case (state_r)
        HOST_IDLE: begin
          if (i_cmd_valid && i_cmd_bits != 6'h00) begin
            cs_n_r      <= 1'b0;
            tx_r        <= {i_cmd_op, i_cmd_addr};
            si_r        <= i_cmd_op[7];
            left_r      <= i_cmd_bits;
            o_cmd_ready <= 1'b0;
            state_r     <= HOST_LOW;
          end
        end
        HOST_LOW: begin
          if (div_done) begin
            sclk_r  <= 1'b1;
            rx_r    <= {rx_r[6:0], so_sync_r};
            state_r <= HOST_HIGH;
          end
        end
        HOST_HIGH: begin
          if (div_done) begin
            sclk_r <= 1'b0;
            if (left_r == 6'h01) begin
              state_r <= HOST_TRAIL;
            end else begin
              tx_r    <= {tx_r[30:0], 1'b0};
              si_r    <= tx_r[30];
              left_r  <= left_r - 6'h01;
              state_r <= HOST_LOW;
            end
          end
        end
        HOST_TRAIL: begin
          if (div_done) begin
            cs_n_r      <= 1'b1;
            o_rsp_valid <= 1'b1;
            o_rsp_data  <= rx_r;
            state_r     <= HOST_GAP;
          end
        end
        HOST_GAP: begin
          if (div_done) begin
            o_cmd_ready <= 1'b1;
            state_r     <= HOST_IDLE;
          end
        end
        default: begin
          state_r <= HOST_IDLE;
        end
      endcase
    end
  end

  assign link.sclk = sclk_r;
  assign link.cs_n = cs_n_r;
  assign link.si   = si_r;

endmodule
`default_nettype wire

/* File: verification/flash_erase_monitor.sv */
`default_nettype none
module flash_erase_monitor
  import flash_erase_pkg::*;
#(
  parameter int unsigned PAGE_CYCLES   = 700,
  parameter int unsigned SECTOR_CYCLES = 720,
  parameter int unsigned HALF_CYCLES   = 740,
  parameter int unsigned BLOCK_CYCLES  = 760,
  parameter int unsigned CHIP_CYCLES   = 780
) (
  input  wire logic          i_clk_sys,       // system clock
  input  wire logic          i_rst,           // sync reset
  input  wire logic          i_sclk,          // link clock
  input  wire logic          i_cs_n,          // link select
  input  wire logic          i_so_oe,         // device drives so
  input  wire logic          i_wip,           // erase running
  input  wire logic          i_wel,           // write enable latch
  input  wire logic          i_erase_start,   // start pulse
  input  var erase_kind_type i_erase_kind,    // running kind
  input  wire logic [23:0]   i_erase_base,    // region base
  input  wire logic          i_erase_done,    // done pulse
  input  wire logic          i_cmd_rejected   // refuse pulse
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  logic [15:0] run_cnt_r;
  int unsigned exp_len;

  always_comb begin
    case (i_erase_kind)
      ERASE_PAGE:       exp_len = PAGE_CYCLES;
      ERASE_SECTOR:     exp_len = SECTOR_CYCLES;
      ERASE_HALF_BLOCK: exp_len = HALF_CYCLES;
      ERASE_BLOCK:      exp_len = BLOCK_CYCLES;
      default:          exp_len = CHIP_CYCLES;
    endcase
  end

  // 1 in the cycle after start; done comes in the same cycle that busy falls, so it sees N
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      run_cnt_r <= 16'h0000;
    end else if (i_erase_start) begin
      run_cnt_r <= 16'h0001;
    end else if (i_wip) begin
      run_cnt_r <= run_cnt_r + 16'h0001;
    end
  end

  a_erase_length: assert property (i_erase_done |-> 32'(run_cnt_r) == exp_len)
    else $error("erase length wrong for its kind");
  a_start_wel_set: assert property (i_erase_start |-> $past(i_wel))
    else $error("erase started without latch");
  a_start_clears_wel: assert property (i_erase_start |-> i_wip && !i_wel)
    else $error("start without busy or latch still set");
  a_wip_from_start: assert property ($rose(i_wip) |-> i_erase_start)
    else $error("busy rose without start");
  a_busy_no_start: assert property (i_wip && !i_erase_done |=> !i_erase_start)
    else $error("new erase started while busy");
  a_done_drops_wip: assert property (i_erase_done == $fell(i_wip))
    else $error("busy not ended by done");
  a_answer_after_cs: assert property ((i_erase_start || i_cmd_rejected) |-> $past(i_cs_n, 2) && !$past(i_cs_n, 7))
    else $error("erase verdict not tied to select rise");
  a_idle_clock_low: assert property (i_cs_n |-> !i_sclk)
    else $error("link clock high outside frame");
  a_so_released: assert property (i_cs_n && $past(i_cs_n) |-> !i_so_oe)
    else $error("serial output driven while deselected");
  a_chip_base_zero: assert property (i_erase_start && i_erase_kind == ERASE_CHIP |-> i_erase_base == 24'h000000)
    else $error("chip erase base not zero");
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
`default_nettype none
module testbench
  import flash_erase_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic           i_clk_sys = 1'b0;
  logic           i_rst = 1'b1;
  logic [4:0]     protect;
  logic           cmd_valid;
  logic [7:0]     cmd_op;
  logic [23:0]    cmd_addr;
  logic [5:0]     cmd_bits;
  logic           cmd_ready, rsp_valid, write_in_progress, write_enable_latch, start, done, rej;
  logic [7:0]     rsp_data;
  logic [23:0]    base, seen_base;
  erase_kind_type kind, seen_kind;
  int             fail_count, checks_done, n_start, n_rej, n_done;

  always #2 i_clk_sys = ~i_clk_sys;

  flash_link_if link ();
  flash_erase_device #(.PAGE_CYCLES(700), .SECTOR_CYCLES(720), .HALF_CYCLES(740),
    .BLOCK_CYCLES(760), .CHIP_CYCLES(780)) i_flash_erase_device (.i_clk_sys(i_clk_sys),
    .i_rst(i_rst), .i_protect(protect), .o_wip(write_in_progress), .o_wel(write_enable_latch), .o_erase_start(start),
    .o_erase_kind(kind), .o_erase_base(base), .o_erase_done(done), .o_cmd_rejected(rej), .link(link));
  flash_erase_host i_flash_erase_host (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_cmd_valid(cmd_valid),
    .i_cmd_op(cmd_op), .i_cmd_addr(cmd_addr), .i_cmd_bits(cmd_bits), .o_cmd_ready(cmd_ready),
    .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data), .link(link));
  flash_erase_monitor #(.PAGE_CYCLES(700), .SECTOR_CYCLES(720), .HALF_CYCLES(740), .BLOCK_CYCLES(760),
    .CHIP_CYCLES(780)) i_flash_erase_monitor (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_sclk(link.sclk),
    .i_cs_n(link.cs_n), .i_so_oe(link.so_oe), .i_wip(write_in_progress), .i_wel(write_enable_latch), .i_erase_start(start),
    .i_erase_kind(kind), .i_erase_base(base), .i_erase_done(done), .i_cmd_rejected(rej));

  // pulses last one cycle, so they are tallied where they cannot be missed
  always @(negedge i_clk_sys) begin
    if (start) begin
      n_start++;
      seen_kind = kind;
      seen_base = base;
    end
    if (rej) n_rej++;
    if (done) n_done++;
  end

  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask

  task wait_for(input int sel, input logic lvl);
    int i;
    logic v;
    for (i = 0; i < 2000; i++) begin
      @(negedge i_clk_sys);
      v = (sel == 0) ? cmd_ready : (sel == 1) ? rsp_valid : write_in_progress;
      if (v === lvl) return;
    end
    fail_count++;
    give_verdict();
  endtask

  task send(input logic [7:0] op, input logic [23:0] addr, input logic [5:0] bits);
    wait_for(0, 1'b1);
    cmd_op = op;
    cmd_addr = addr;
    cmd_bits = bits;
    cmd_valid = 1'b1;
    @(negedge i_clk_sys);
    cmd_valid = 1'b0;
    wait_for(1, 1'b1);
  endtask

  task erase_try(input logic [7:0] op, input logic [23:0] addr, input logic [5:0] bits,
                 input logic wren, input logic ok, input erase_kind_type k, input logic [23:0] b);
    int s0, r0, d0;
    if (wren) begin
      send(8'h06, 24'h000000, 6'h08);
      repeat (8) @(negedge i_clk_sys);
      chk("wel set", 32'(write_enable_latch), 32'h1);
    end
    s0 = n_start;
    r0 = n_rej;
    d0 = n_done;
    send(op, addr, bits);
    repeat (8) @(negedge i_clk_sys);
    chk("started", 32'(n_start - s0), 32'(ok));
    chk("refused", 32'(n_rej - r0), 32'(!ok));
    if (ok) begin
      chk("kind", 32'(seen_kind), 32'(k));
      chk("base", 32'(seen_base), 32'(b));
      send(8'h05, 24'h000000, 6'h10);
      chk("busy status", 32'(rsp_data), 32'({1'b0, protect, 2'b01}));
      send(op, addr, bits);
      repeat (8) @(negedge i_clk_sys);
      chk("busy refuse", 32'(n_rej - r0), 32'h1);
      wait_for(2, 1'b0);
      // done stands in the first idle cycle; let its tally run first
      @(negedge i_clk_sys);
      chk("done", 32'(n_done - d0), 32'h1);
      chk("one start", 32'(n_start - s0), 32'h1);
    end
  endtask

  logic [7:0]     ops [6] = '{8'h81, 8'h20, 8'h52, 8'hD8, 8'h60, 8'hC7};
  logic [5:0]     lens [6] = '{6'h20, 6'h20, 6'h20, 6'h20, 6'h08, 6'h08};
  erase_kind_type kinds [6] = '{ERASE_PAGE, ERASE_SECTOR, ERASE_HALF_BLOCK, ERASE_BLOCK, ERASE_CHIP, ERASE_CHIP};
  logic [23:0]    bases [6] = '{24'h0ABC00, 24'h0AB000, 24'h0A8000, 24'h0A0000, 24'h000000, 24'h000000};

  initial begin
    cmd_valid = 1'b0;
    cmd_op = 8'h00;
    cmd_addr = 24'h000000;
    cmd_bits = 6'h00;
    protect = 5'h00;
    repeat (10) @(negedge i_clk_sys);
    i_rst = 1'b0;
    chk("wip idle", 32'(write_in_progress), 32'h0);
    chk("wel idle", 32'(write_enable_latch), 32'h0);
    send(8'h06, 24'h000000, 6'h08);
    send(8'h05, 24'h000000, 6'h10);
    chk("idle status", 32'(rsp_data), 32'h02);
    for (int i = 0; i < 6; i++) erase_try(ops[i], 24'h0ABCDE, lens[i], 1'b1, 1'b1, kinds[i], bases[i]);
    send(8'h06, 24'h000000, 6'h08);
    send(8'h04, 24'h000000, 6'h08);
    repeat (8) @(negedge i_clk_sys);
    chk("wel cleared", 32'(write_enable_latch), 32'h0);
    erase_try(8'h20, 24'h001000, 6'h20, 1'b0, 1'b0, ERASE_PAGE, 24'h000000);
    erase_try(8'h81, 24'h001000, 6'h1F, 1'b1, 1'b0, ERASE_PAGE, 24'h000000);
    erase_try(8'h52, 24'h001000, 6'h21, 1'b1, 1'b0, ERASE_PAGE, 24'h000000);
    erase_try(8'hD8, 24'h001000, 6'h28, 1'b1, 1'b0, ERASE_PAGE, 24'h000000);
    erase_try(8'h60, 24'h000000, 6'h10, 1'b1, 1'b0, ERASE_PAGE, 24'h000000);
    protect = 5'h01;
    for (int i = 0; i < 4; i++) erase_try(ops[i], 24'h1F8765, 6'h20, 1'b1, 1'b0, ERASE_PAGE, 24'h000000);
    erase_try(8'hC7, 24'h000000, 6'h08, 1'b1, 1'b0, ERASE_PAGE, 24'h000000);
    erase_try(8'h81, 24'h000123, 6'h20, 1'b1, 1'b1, ERASE_PAGE, 24'h000100);
    protect = 5'h10;
    erase_try(8'h60, 24'h000000, 6'h08, 1'b1, 1'b0, ERASE_PAGE, 24'h000000);
    give_verdict();
  end
endmodule
`default_nettype wire
